// file: logic/async_rx.sv
`timescale 1ns/1ps
module async_rx #(
  parameter int DEPTH = 3
) (
  // Clock and reset
  input  logic       clk,
  input  logic       sys_rst,
  // Control
  input  logic       soft_rst,
  input  logic       enable,
  input  logic       tick,
  input  logic       x1,
  input  logic       rxd,
  input  logic       pop,
  // Status and data
  output logic [7:0] data,
  output logic       not_empty,
  output logic       full,
  output logic       rts_ok
);
  import uart_fc_pkg::*;
  rx_state_t   state;
  logic [2:0]  samp;
  logic        filt;
  logic [3:0]  sub;
  logic [2:0]  bitn;
  logic [7:0]  shreg;
  logic        held;
  logic [7:0]  mem [DEPTH];
  logic [1:0]  rd;
  logic [1:0]  wr;
  logic [2:0]  count;
  logic        push;
  logic        done;

  // Majority vote kills single-sample glitches in 16x mode
  assign filt = x1 ? samp[0] : ((samp[0] & samp[1]) | (samp[1] & samp[2]) |
                                (samp[0] & samp[2])); // [RULE22]
  assign done = tick && state == RX_STOP && (x1 || sub == LAST_SUB);
  assign push = (done && count < 3'(DEPTH)) || (pop && held);
  assign full = count == 3'(DEPTH);
  assign not_empty = count != 3'h0;
  assign data = mem[rd];

  always_ff @(posedge clk) begin
    if (sys_rst) samp <= 3'h7;
    else if (tick) samp <= {samp[1:0], rxd};
  end

  // Soft reset only restarts the state machine; data stays
  always_ff @(posedge clk) begin
    if (sys_rst || soft_rst) begin // [RULE20]
      state <= RX_IDLE;
      sub   <= 4'h0;
      bitn  <= 3'h0;
    end else if (tick) begin
      sub <= sub + 4'h1;
      case (state)
        RX_IDLE: if (enable && !filt && !held) begin
          state <= RX_START;
          sub   <= 4'h0;
        end
        RX_START: if (x1 || sub == RX_MID) begin
          sub  <= 4'h0;
          bitn <= 3'h0;
          state <= filt ? RX_IDLE : RX_DATA; // [RULE22]
        end
        RX_DATA: if (x1 || sub == LAST_SUB) begin
          shreg <= {filt, shreg[7:1]};
          bitn  <= bitn + 3'h1;
          if (bitn == 3'h7) state <= RX_STOP;
        end
        RX_STOP: if (x1 || sub == LAST_SUB) state <= RX_IDLE;
        default: state <= RX_IDLE;
      endcase
    end
  end

  // Fourth character waits in the shift register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd    <= 2'h0;
      wr    <= 2'h0;
      count <= 3'h0;
      held  <= 1'b0;
    end else begin
      if (push) begin
        mem[wr] <= shreg;
        wr <= (wr == 2'(DEPTH - 1)) ? 2'h0 : wr + 2'h1;
      end
      if (pop && not_empty) rd <= (rd == 2'(DEPTH - 1)) ? 2'h0 : rd + 2'h1;
      count <= count + 3'(push) - 3'(pop && not_empty);
      if (done && full) held <= 1'b1; // [RULE7]
      else if (pop) held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) rts_ok <= 1'b1;
    else if (pop) rts_ok <= 1'b1;
    else if (tick && state == RX_IDLE && enable && !filt && full)
      rts_ok <= 1'b0; // [RULE7]
  end
endmodule // async_rx

// file: logic/rate_if.sv
`timescale 1ns/1ps
interface rate_if;
  logic [3:0] code;
  logic       alt;
  logic       test;
  logic       force1x;
  logic       ext_edge;
  logic       timer_tick;
  logic       tick;
  logic       x1;
  modport gen (input code, alt, test, force1x, ext_edge, timer_tick,
               output tick, x1);
  modport user (output code, alt, test, force1x, ext_edge, timer_tick,
                input tick, x1);
endinterface

// file: logic/rate_tick.sv
`timescale 1ns/1ps
module rate_tick (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Selection and tick
  rate_if.gen bus
);
  import uart_fc_pkg::*;
  logic [15:0] cnt;
  logic [15:0] div;

  always_comb div = rate_div(bus.code, bus.alt, bus.test); // [RULE17]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt      <= 16'h0000;
      bus.tick <= 1'b0;
    end else begin
      case (bus.code) // [RULE17]
        CSEL_TIMER: bus.tick <= bus.timer_tick;
        CSEL_EXT16,
        CSEL_EXT1:  bus.tick <= bus.ext_edge;
        default: begin
          if (cnt >= div - 16'h0001) begin
            cnt      <= 16'h0000;
            bus.tick <= 1'b1;
          end else begin
            cnt      <= cnt + 16'h0001;
            bus.tick <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) bus.x1 <= 1'b0;
    else bus.x1 <= (bus.code == CSEL_EXT1) | bus.force1x; // [RULE19]
  end
endmodule // rate_tick

// file: logic/uart_fc_pkg.sv
package uart_fc_pkg;
  localparam int          CLK_HZ     = 40_000_000;
  localparam int          TENTHS     = 10;
  localparam int          TICKS_BIT  = 16;
  // Register indices; byte address is four times the index
  localparam logic [3:0]  REG_MODE_A = 4'h0;
  localparam logic [3:0]  REG_STAT_A = 4'h1;
  localparam logic [3:0]  REG_CMD_A  = 4'h2;
  localparam logic [3:0]  REG_DATA_A = 4'h3;
  localparam logic [3:0]  REG_AUX    = 4'h4;
  localparam logic [3:0]  REG_OSRC   = 4'h5;
  localparam logic [3:0]  REG_LATCH  = 4'h6;
  localparam logic [3:0]  REG_MODE_B = 4'h8;
  localparam logic [3:0]  REG_STAT_B = 4'h9;
  localparam logic [3:0]  REG_CMD_B  = 4'ha;
  localparam logic [3:0]  REG_DATA_B = 4'hb;
  localparam logic [3:0]  REG_SET    = 4'he;
  localparam logic [3:0]  REG_CLR    = 4'hf;
  // Field positions
  localparam int          MODE_RX_RTS = 7;
  localparam int          MODE_PAR_LO = 3;
  localparam int          MODE_CTS    = 12;
  localparam int          MODE_TX_RTS = 13;
  localparam int          AUX_ALT     = 7;
  localparam int          CMD_RX_EN   = 0;
  localparam int          CMD_RX_DIS  = 1;
  localparam int          CMD_TX_EN   = 2;
  localparam int          CMD_TX_DIS  = 3;
  // Command codes in the upper nibble
  localparam logic [3:0]  CMD_RST_RX  = 4'h2;
  localparam logic [3:0]  CMD_RST_TX  = 4'h3;
  localparam logic [3:0]  CMD_RTS_ON  = 4'h8;
  localparam logic [3:0]  CMD_RTS_OFF = 4'h9;
  // Clock select codes
  localparam logic [3:0]  CSEL_TIMER  = 4'hd;
  localparam logic [3:0]  CSEL_EXT16  = 4'he;
  localparam logic [3:0]  CSEL_EXT1   = 4'hf;
  localparam logic [1:0]  WAKE_UP     = 2'h3;
  localparam logic [3:0]  ABORT_16THS = 4'h3;
  localparam logic [3:0]  LAST_SUB    = 4'hf;
  localparam logic [3:0]  RX_MID      = 4'h7;
  localparam logic [15:0] MODE_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  function automatic int pick4(input int n0, input int n1, input int t0,
                               input int t1, input logic alt,
                               input logic test);
    return test ? (alt ? t1 : t0) : (alt ? n1 : n0);
  endfunction

  // Divider per 16x tick; rates in tenths of a baud
  function automatic logic [15:0] rate_div(input logic [3:0] code,
                                           input logic alt,
                                           input logic test);
    int t;
    t = 500;
    case (code)
      4'h0:    t = pick4(500, 750, 48000, 72000, alt, test);
      4'h1:    t = pick4(1100, 1100, 8800, 8800, alt, test);
      4'h2:    t = pick4(1345, 1345, 10760, 10760, alt, test);
      4'h3:    t = pick4(2000, 1500, 192000, 144000, alt, test);
      4'h4:    t = pick4(3000, 3000, 288000, 288000, alt, test);
      4'h5:    t = pick4(6000, 6000, 576000, 576000, alt, test);
      4'h6:    t = pick4(12000, 12000, 1152000, 1152000, alt, test);
      4'h7:    t = pick4(10500, 20000, 10500, 20000, alt, test);
      4'h8:    t = pick4(24000, 24000, 576000, 576000, alt, test);
      4'h9:    t = pick4(48000, 48000, 48000, 48000, alt, test);
      4'ha:    t = pick4(72000, 18000, 576000, 144000, alt, test);
      4'hb:    t = pick4(96000, 96000, 96000, 96000, alt, test);
      4'hc:    t = pick4(384000, 192000, 384000, 192000, alt, test);
      default: t = 500;
    endcase
    return 16'(CLK_HZ * TENTHS / (TICKS_BIT * t));
  endfunction
endpackage

// file: logic/uart_flow_ctl.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Pin fed from the latch shows the inverse of its latch bit.
// [RULE2] Set and clear port writes touch only positions holding a one.
// [RULE3] Source config picks pins two to seven; modes and commands pin 0-1.
// [RULE4] Clear-to-send: input pin zero for A, pin one for B, active low.
// [RULE5] Request-to-send: output pin zero for A, pin one for B, low.
// [RULE6] With gate bit set, sending waits while clear-to-send is high.
// [RULE7] Full buffer plus fourth start bit raises request-to-send.
// [RULE8] Receiver RTS mode bit hands pin zero or one to the receiver.
// [RULE9] Transmitter may drive the same pin; both at once is allowed.
// [RULE10] Commands 1000 and 1001 change request-to-send on the pin.
// [RULE11] RTS pin is NAND of latch bit and receiver signal.
// [RULE12] Flow control off returns pins zero and one to the latch.
// [RULE13] Disable within 3/16 bit (16x) or one bit (1x) sends nothing.
// [RULE14] Disable right after loading in underrun drops that character.
// [RULE15] Transmitter empty is set in underrun or just after enabling.
// [RULE16] Holding moves to shifter in start bit; ready sets at its end.
// [RULE17] Four-bit code picks rate from two sets, timer or external clock.
// [RULE18] Every read at index two toggles the rate test set.
// [RULE19] Index ten test mode forces 1x and shows internal nodes.
// [RULE20] Receiver reset then enable recovers, keeping data and setup.
// [RULE21] In wake-up mode software leaves it, resets, then re-enters.
// [RULE22] Receiver filters input and rejects noisy start bits; code filters only in 16x mode, 1x uses the raw sample.
// [RULE23] Software should watch errors and use data-stopped timeouts.
module uart_flow_ctl (
  // Clock and reset
  input  logic        clk,
  input  logic        sys_rst,
  // Register bus
  input  logic [5:0]  address,
  input  logic        read,
  input  logic        write,
  input  logic [31:0] writedata,
  input  logic [3:0]  byteenable,
  output logic [31:0] readdata,
  output logic        waitrequest,
  // Serial lines
  input  logic        rxd_a,
  input  logic        rxd_b,
  output logic        txd_a,
  output logic        txd_b,
  // Port pins and timer
  input  logic [6:0]  in_pins,
  output logic [7:0]  out_pins,
  input  logic        timer_tick
);
  import uart_fc_pkg::*;

  logic [15:0] mode [2];
  logic [7:0]  csel [2];
  logic [7:0]  aux;
  logic [7:0]  output_source_config;
  logic [7:0]  output_latch;
  logic        brg_test;
  logic        x1_test;
  logic [6:0]  in_meta;
  logic [6:0]  in_sync;
  logic        io2_prev;
  logic [1:0]  rxd_meta;
  logic [1:0]  rxd_sync;
  logic [3:0]  idx;
  logic        rd_take;
  logic        wr_take;
  logic [1:0]  cmd_take;
  logic [1:0]  data_wr;
  logic [1:0]  pop;
  logic [3:0]  tick;
  logic [3:0]  x1;
  logic [1:0]  tx_ready;
  logic [1:0]  tx_empty;
  logic [1:0]  rx_ready;
  logic [1:0]  rx_full;
  logic [1:0]  rts_ok;
  logic [1:0]  cts_ok;
  logic [1:0]  flow_sig;
  logic [1:0]  flow_sel;
  logic [1:0]  rx_en;
  logic [1:0]  rx_rst;
  logic [1:0]  txd;
  logic [1:0]  tick_tog;
  logic [7:0]  rx_data [2];
  logic [7:0]  func;
  logic [7:0]  next_out;
  tx_state_t   tx_state [2];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  assign idx     = address[5:2];
  assign rd_take = read & ~waitrequest;
  assign wr_take = write & ~waitrequest & byteenable[0];
  assign txd_a   = txd[0];
  assign txd_b   = txd[1];

  // Pins come from outside the clock domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_meta  <= 7'h7f;
      in_sync  <= 7'h7f;
      io2_prev <= 1'b1;
      rxd_meta <= 2'h3;
      rxd_sync <= 2'h3;
    end else begin
      in_meta  <= in_pins;
      in_sync  <= in_meta;
      io2_prev <= in_sync[2];
      rxd_meta <= {rxd_b, rxd_a};
      rxd_sync <= rxd_meta;
    end
  end

  // One wait cycle; read data is caught while waitrequest is still high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if ((read | write) & waitrequest) begin
      waitrequest <= 1'b0;
      case (idx)
        REG_MODE_A: readdata <= {16'h0000, mode[0]};
        REG_MODE_B: readdata <= {16'h0000, mode[1]};
        REG_STAT_A: readdata <= {28'h0000000, tx_empty[0], tx_ready[0],
                                 rx_full[0], rx_ready[0]};
        REG_STAT_B: readdata <= {28'h0000000, tx_empty[1], tx_ready[1],
                                 rx_full[1], rx_ready[1]};
        REG_DATA_A: readdata <= {24'h000000, rx_data[0]};
        REG_DATA_B: readdata <= {24'h000000, rx_data[1]};
        REG_AUX:    readdata <= {22'h000000, x1_test, brg_test, aux};
        REG_OSRC:   readdata <= {24'h000000, output_source_config};
        REG_LATCH:  readdata <= {24'h000000, output_latch};
        default:    readdata <= 32'h0000_0000;
      endcase
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brg_test <= 1'b0;
      x1_test  <= 1'b0;
    end else begin
      if (rd_take && hit(idx, REG_CMD_A)) brg_test <= ~brg_test; // [RULE18]
      if (rd_take && hit(idx, REG_CMD_B)) x1_test <= ~x1_test; // [RULE19]
    end
  end

  // Enabling flow control never touches the latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode[0] <= MODE_RST;
      mode[1] <= MODE_RST;
      csel[0] <= BYTE_RST;
      csel[1] <= BYTE_RST;
      aux     <= BYTE_RST;
      output_source_config <= BYTE_RST;
    end else if (wr_take) begin
      case (idx)
        REG_MODE_A: begin
          mode[0][7:0] <= writedata[7:0];
          if (byteenable[1]) mode[0][15:8] <= writedata[15:8];
        end
        REG_MODE_B: begin
          mode[1][7:0] <= writedata[7:0];
          if (byteenable[1]) mode[1][15:8] <= writedata[15:8];
        end
        REG_STAT_A: csel[0] <= writedata[7:0];
        REG_STAT_B: csel[1] <= writedata[7:0];
        REG_AUX:    aux <= writedata[7:0];
        REG_OSRC:   output_source_config <= writedata[7:0]; // [RULE3]
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_latch <= BYTE_RST;
    end else if (wr_take && hit(idx, REG_SET)) begin
      output_latch <= output_latch | writedata[7:0]; // [RULE2]
    end else if (wr_take && hit(idx, REG_CLR)) begin
      output_latch <= output_latch & ~writedata[7:0]; // [RULE2]
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cmd_take[c] && writedata[7:4] == CMD_RTS_ON)
          output_latch[c] <= 1'b1; // [RULE10]
        else if (cmd_take[c] && writedata[7:4] == CMD_RTS_OFF)
          output_latch[c] <= 1'b0; // [RULE10]
      end
    end
  end

  // Rate generators: 0,1 transmitters; 2,3 receivers
  for (genvar g = 0; g < 4; g++) begin : g_rate
    rate_if rif ();
    assign rif.code = (g < 2) ? csel[g % 2][3:0] : csel[g % 2][7:4];
    assign rif.alt = aux[AUX_ALT];
    assign rif.test = brg_test; // [RULE18]
    assign rif.force1x = x1_test; // [RULE19]
    assign rif.ext_edge = in_sync[2] & ~io2_prev;
    assign rif.timer_tick = timer_tick;
    assign tick[g] = rif.tick;
    assign x1[g] = rif.x1;
    rate_tick u_rate (
      .clk     (clk),
      .sys_rst (sys_rst),
      .bus     (rif.gen)
    );
  end

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [3:0] sub;
    logic [2:0] bitn;
    logic [7:0] shreg;
    logic [7:0] thr;
    logic       thr_full;
    logic       tx_en;
    logic       bit_end;
    logic       abort;
    logic [3:0] cmd;

    assign cmd_take[c] = wr_take && hit(idx, c ? REG_CMD_B : REG_CMD_A);
    assign data_wr[c]  = wr_take && hit(idx, c ? REG_DATA_B : REG_DATA_A);
    assign pop[c]      = rd_take && hit(idx, c ? REG_DATA_B : REG_DATA_A);
    assign cmd         = writedata[7:4];
    assign cts_ok[c]   = ~mode[c][MODE_CTS] | ~in_sync[c]; // [RULE4] [RULE6]
    assign bit_end     = x1[c] || sub == LAST_SUB;
    assign tx_ready[c] = ~thr_full;
    assign tx_empty[c] = tx_state[c] == TX_IDLE; // [RULE15]
    // Disabled while loaded and still idle, or too early in the start bit: the character is dropped
    assign abort = cmd_take[c] && writedata[CMD_TX_DIS] &&
                   ((tx_state[c] == TX_IDLE && thr_full) ||
                    (tx_state[c] == TX_START &&
                     (x1[c] || sub < ABORT_16THS))); // [RULE13] [RULE14]

    always_ff @(posedge clk) begin
      if (sys_rst) tx_en <= 1'b0;
      else if (cmd_take[c] && cmd == CMD_RST_TX) tx_en <= 1'b0;
      else if (cmd_take[c] && writedata[CMD_TX_DIS]) tx_en <= 1'b0;
      else if (cmd_take[c] && writedata[CMD_TX_EN]) tx_en <= 1'b1;
    end

    always_ff @(posedge clk) begin
      if (sys_rst || (cmd_take[c] && cmd == CMD_RST_TX) || abort) begin
        tx_state[c] <= TX_IDLE;
        thr_full    <= 1'b0;
        txd[c]      <= 1'b1;
        sub         <= 4'h0;
        bitn        <= 3'h0;
      end else begin
        if (tick[c]) begin
          sub <= sub + 4'h1;
          case (tx_state[c])
            // Gate only between characters so the current one finishes
            TX_IDLE: if (tx_en && thr_full && cts_ok[c]) begin // [RULE6]
              tx_state[c] <= TX_START;
              shreg       <= thr; // [RULE16]
              txd[c]      <= 1'b0;
              sub         <= 4'h0;
            end
            TX_START: if (bit_end) begin
              thr_full    <= 1'b0; // [RULE16]
              tx_state[c] <= TX_DATA;
              txd[c]      <= shreg[0];
              bitn        <= 3'h0;
            end
            TX_DATA: if (bit_end) begin
              shreg <= {1'b1, shreg[7:1]};
              bitn  <= bitn + 3'h1;
              txd[c] <= (bitn == 3'h7) ? 1'b1 : shreg[1];
              if (bitn == 3'h7) tx_state[c] <= TX_STOP;
            end
            TX_STOP: if (bit_end) tx_state[c] <= TX_IDLE;
            default: tx_state[c] <= TX_IDLE;
          endcase
        end
        if (data_wr[c]) begin
          thr      <= writedata[7:0];
          thr_full <= 1'b1;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        rx_en[c]  <= 1'b0;
        rx_rst[c] <= 1'b0;
      end else begin
        rx_rst[c] <= cmd_take[c] && cmd == CMD_RST_RX; // [RULE20]
        if (cmd_take[c] && cmd == CMD_RST_RX) rx_en[c] <= 1'b0;
        else if (cmd_take[c] && writedata[CMD_RX_DIS]) rx_en[c] <= 1'b0;
        else if (cmd_take[c] && writedata[CMD_RX_EN]) rx_en[c] <= 1'b1;
      end
    end

    async_rx #(.DEPTH(3)) u_rx (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .soft_rst  (rx_rst[c]),
      .enable    (rx_en[c]),
      .tick      (tick[c + 2]),
      .x1        (x1[c + 2]),
      .rxd       (rxd_sync[c]),
      .pop       (pop[c]),
      .data      (rx_data[c]),
      .not_empty (rx_ready[c]),
      .full      (rx_full[c]),
      .rts_ok    (rts_ok[c])
    );

    // Receiver and transmitter may share the pin
    assign flow_sel[c] = mode[c][MODE_RX_RTS] | mode[c][MODE_TX_RTS]; // [RULE8] [RULE9]
    assign flow_sig[c] = (~mode[c][MODE_RX_RTS] | rts_ok[c]) &
                         (~mode[c][MODE_TX_RTS] | ~tx_empty[c]); // [RULE9]

    always_ff @(posedge clk) begin
      if (sys_rst) tick_tog[c] <= 1'b0;
      else if (tick[c]) tick_tog[c] <= ~tick_tog[c];
    end
  end

  assign func = {~tx_ready[1], ~tx_ready[0], ~rx_ready[1], ~rx_ready[0],
                 tick_tog[1], tick_tog[0], 2'h0};

  always_comb begin
    next_out = ~output_latch; // [RULE1]
    for (int c = 0; c < 2; c++)
      if (flow_sel[c])
        next_out[c] = ~(output_latch[c] & flow_sig[c]); // [RULE5] [RULE11] [RULE12]
    for (int k = 2; k < 8; k++)
      if (output_source_config[k]) next_out[k] = func[k]; // [RULE3]
    if (x1_test)
      next_out = {rxd_sync, txd, rts_ok, tx_empty}; // [RULE19]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) out_pins <= 8'hff;
    else out_pins <= next_out;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_LATCH_INVERT: assert property ( // [RULE1]
    !output_source_config[7] && !x1_test |=> out_pins[7] == !$past(output_latch[7]))
    else $error("latch pin not inverted");
  AST_SET_BITS: assert property ( // [RULE2]
    wr_take && hit(idx, REG_SET) |=>
      output_latch == ($past(output_latch) | $past(writedata[7:0])))
    else $error("set bits wrong");
  AST_CLEAR_BITS: assert property ( // [RULE2]
    wr_take && hit(idx, REG_CLR) |=>
      output_latch == ($past(output_latch) & ~$past(writedata[7:0])))
    else $error("clear bits wrong");
  AST_CTS_HOLD: assert property ( // [RULE6]
    tx_state[0] == TX_IDLE && mode[0][MODE_CTS] && in_sync[0] &&
    !cmd_take[0] |=> tx_state[0] == TX_IDLE)
    else $error("sent while clear-to-send high");
  AST_RTS_NAND: assert property ( // [RULE11]
    flow_sel[0] && !x1_test |=>
      out_pins[0] == !($past(output_latch[0]) && $past(flow_sig[0])))
    else $error("rts pin not nand");
  AST_RTS_CMD: assert property ( // [RULE10]
    cmd_take[1] && writedata[7:4] == CMD_RTS_ON |=> output_latch[1])
    else $error("rts command ignored");
  AST_READY_AFTER_START: assert property ( // [RULE16]
    tx_state[0] == TX_START ##1 tx_state[0] == TX_DATA |-> tx_ready[0] || $past(data_wr[0]))
    else $error("ready not set after start bit");
  AST_TEST_TOGGLE: assert property ( // [RULE18]
    rd_take && hit(idx, REG_CMD_A) |=> brg_test != $past(brg_test))
    else $error("test mode not toggled");
  AST_ABORT: assert property ( // [RULE13]
    g_ch[0].abort |=> tx_state[0] == TX_IDLE && tx_ready[0] && txd[0])
    else $error("early disable still sends");
  AST_BUS_ANSWER: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("no bus answer");

  COV_TX_CHAR: cover property (tx_state[0] == TX_STOP ##1 tx_state[0] == TX_IDLE);
  COV_RTS_HIGH: cover property (flow_sel[0] && $fell(rts_ok[0]));
  COV_ABORT: cover property (g_ch[1].abort);
  COV_RX_FULL: cover property (rx_full[1]);
endmodule // uart_flow_ctl

// file: test/serial_remote.sv
`timescale 1ns/1ps
module serial_remote #(
  parameter int BIT_CLKS = 336
) (
  input  wire logic clk,
  output logic      line
);
  initial line = 1'b1;
  // Line rests at its pull-up level between frames
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask
endmodule // serial_remote

// file: test/uart_flow_control_baud_select_bench.sv
`timescale 1ns/1ps
module uart_flow_control_baud_select_bench;
  import uart_fc_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [5:0]  address = 6'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rxd_a;
  logic        txd_a;
  logic [7:0]  out_pins;
  logic [6:0]  in_drive = 7'h7f;
  logic [31:0] rd;
  int          bad_count = 0;
  int          checks_done = 0;
  bit          low_seen = 1'b0;

  always #12.5 clk = ~clk;

  uart_flow_ctl dut_u (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .rxd_a(rxd_a), .rxd_b(1'b1), .txd_a(txd_a), .txd_b(),
    .in_pins(in_drive), .out_pins(out_pins), .timer_tick(1'b0));
  serial_remote #(.BIT_CLKS(336)) far_u (.clk(clk), .line(rxd_a));

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Records any low level on the line over 700 cycles
  task automatic watch_tx;
    low_seen = 1'b0;
    repeat (700) begin
      @(posedge clk);
      if (txd_a !== 1'b1) low_seen = 1'b1;
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [3:0] idx,
                     input logic [31:0] wd);
    int n;
    n = 0;
    address <= {idx, 2'b00};
    write <= wr;
    read <= !wr;
    writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // Pins register one edge after the take; let them settle
    @(posedge clk);
    @(posedge clk);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk("pins", 8'hff, out_pins);
    acc(1, REG_SET, 32'h24);
    acc(0, REG_LATCH, 0); chk("latch", 32'h24, rd);
    chk("pins", 8'hdb, out_pins);
    acc(1, REG_CLR, 32'h04); chk("pins", 8'hdf, out_pins);
    acc(1, REG_CMD_A, {CMD_RTS_ON, 4'h0}); chk("rts", 8'hde, out_pins);
    acc(1, REG_CMD_A, {CMD_RTS_OFF, 4'h0}); chk("rts", 8'hdf, out_pins);
    acc(0, 4'h7, 0); chk("unmapped", 32'h0, rd);
    acc(0, REG_CMD_A, 0); acc(0, REG_AUX, 0); chk("test", 32'h100, rd);
    acc(1, REG_STAT_A, 32'h66);
    acc(1, REG_CMD_A, 32'h05);
    acc(0, REG_STAT_A, 0); chk("empty", 32'h8, rd & 32'h8);
    // Disable right after the load: the line must stay idle
    acc(1, REG_DATA_A, 32'h3c); acc(1, REG_CMD_A, 32'h08);
    watch_tx();
    chk("dropped", 0, low_seen);
    acc(1, REG_MODE_A, 32'h1000); acc(1, REG_CMD_A, 32'h04);
    acc(1, REG_DATA_A, 32'h55);
    watch_tx();
    chk("cts held", 0, low_seen);
    in_drive <= 7'h7e;
    watch_tx();
    chk("cts sent", 1, low_seen);
    far_u.send(8'ha5);
    for (int i = 0; i < 200 && rd[0] !== 1'b1; i++) acc(0, REG_STAT_A, 0);
    chk("ready", 1, rd[0]);
    acc(1, REG_MODE_A, 32'h1000);
    acc(1, REG_CMD_A, {CMD_RST_RX, 4'h0}); acc(1, REG_CMD_A, 32'h01);
    acc(1, REG_MODE_A, 32'h1018);
    acc(0, REG_DATA_A, 0); chk("data", 32'ha5, rd);
    report_and_stop();
  end
endmodule // uart_flow_control_baud_select_bench
